// file: include/acmux_pkg.sv
package acmux_pkg;

  // register byte addresses
  localparam logic [7:0] OFF_CSRA = 8'h00;
  localparam logic [7:0] OFF_CSRB = 8'h04;
  localparam logic [7:0] OFF_MUXSEL = 8'h08;
  localparam logic [7:0] OFF_CMP_DIS = 8'h0c;
  localparam logic [7:0] OFF_RES_LO = 8'h10;
  localparam logic [7:0] OFF_RES_HI = 8'h14;
  localparam logic [7:0] OFF_IRQ_ST = 8'h18;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h1c;

  // control/status a field positions
  localparam int CSRA_EN = 7;
  localparam int CSRA_SC = 6;
  localparam int CSRA_ATE = 5;
  localparam int CSRA_IF = 4;
  localparam int CSRA_IE = 3;
  // control/status b, mux select
  localparam int CSRB_MUXEN = 6;
  localparam int MUXSEL_LADJ = 5;
  // irq status / mask bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DROP = 1;

  // reset values
  localparam logic [7:0] RST_CSRA = 8'h00;
  localparam logic [7:0] RST_CSRB = 8'h00;
  localparam logic [7:0] RST_MUXSEL = 8'h00;
  localparam logic [1:0] RST_CMP_DIS = 2'h0;
  localparam logic [9:0] RST_RESULT = 10'h000;

  // conversion lengths in converter clock cycles
  localparam logic [4:0] FIRST_CONV_CLKS = 5'h19;
  localparam logic [4:0] NORMAL_CONV_CLKS = 5'h0d;

  // channel codes
  localparam logic [3:0] CH_BANDGAP = 4'he;
  localparam logic [3:0] CH_GROUND = 4'hf;

  localparam int TRIG_N = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {
    CONV_IDLE,
    CONV_BUSY
  } acmux_conv_state_t;

  // control to the analogue converter
  typedef struct packed {
    logic enable;
    logic active;
    logic pin_valid;
    logic [2:0] pin_channel;
    logic bandgap;
    logic ground;
  } acmux_conv_ctl_t;

  // comparator negative input selection
  typedef struct packed {
    logic from_mux;
    logic [2:0] channel;
  } acmux_cmp_neg_t;

endpackage

// file: core/acmux_prescaler.sv
`timescale 1ns/10ps
module acmux_prescaler #(
  parameter int CNT_W = 7
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire logic [2:0] sel,
  // converter clock tick
  output logic tick
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] term;
  logic tick_q;

  // 000 and 001 both divide by two
  always_comb begin
    if (sel <= 3'h1) begin
      term = CNT_W'(1);
    end else begin
      term = CNT_W'((1 << sel) - 1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= '0;
    end else if (cnt_q >= term) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= run && (cnt_q >= term);
    end
  end

  assign tick = tick_q;

endmodule

// file: core/acmux_top.sv
`timescale 1ns/10ps
// Overview of operation
// - mux enable set, converter off: low channel bits pick comparator negative input
// - mux enable clear or converter on: dedicated negative pin feeds comparator
// - bits 7..2 of comparator input disable register read zero
// - pin input disable bit set: buffer off, port input bit reads zero
// - channel codes 0-7 pins, 14 bandgap, 15 ground, 8-13 reserved
// - converter enable bit turns converter on; clearing it aborts a conversion
// - writing start bit one starts a conversion
// - first conversion after enabling lasts 25 converter clocks, later ones 13
// - start bit reads one while busy; writing zero does nothing
// - auto trigger: rising edge of selected trigger starts a conversion
// - complete flag set when conversion ends and result is stored
// - interrupt only with global enable set and either flag plus enable bit, or drop flag plus drop mask, set
// - flag cleared by interrupt acknowledge or by writing one
// - prescaler select divides system clock by 2 to 128
// - after low byte read, result frozen until high byte read
// - result right adjusted by default, left adjusted when bit set
module acmux_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // axi4-lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // axi4-lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read address
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // axi4-lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // interrupt
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  output logic irq,
  // conversion triggers and analogue side
  input wire logic [acmux_pkg::TRIG_N-1:0] trigger,
  input wire logic [9:0] conv_result,
  output acmux_pkg::acmux_conv_ctl_t conv_ctl,
  // comparator
  output acmux_pkg::acmux_cmp_neg_t cmp_neg,
  input wire logic [1:0] cmp_pin,
  output logic [1:0] cmp_pin_buf_en,
  output logic [1:0] cmp_pin_read
);

  // bus state
  logic aw_got_q;
  logic w_got_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_wr;
  logic ar_hs;
  logic [7:0] rd_val;
  logic rd_hit;

  // registers
  logic en_q;
  logic ate_q;
  logic ie_q;
  logic [2:0] ps_q;
  logic muxen_q;
  logic [2:0] ts_q;
  logic ladj_q;
  logic [3:0] ch_q;
  logic [1:0] dis_q;
  logic drop_mask_q;
  logic flag_q;
  logic drop_q;
  logic [9:0] res_q;
  logic lock_q;

  // engine
  acmux_pkg::acmux_conv_state_t state_q;
  logic [4:0] tcnt_q;
  logic [4:0] target_q;
  logic first_q;
  logic trig_prev_q;
  logic tick;
  logic wr_csra;
  logic en_next;
  logic en_rise;
  logic trig_rise;
  logic start_go;
  logic kill;
  logic conv_done;

  // pin synchronisers
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pin_q;

  function automatic logic is_mapped(input logic [7:0] a);
    return a == acmux_pkg::OFF_CSRA || a == acmux_pkg::OFF_CSRB
        || a == acmux_pkg::OFF_MUXSEL || a == acmux_pkg::OFF_CMP_DIS
        || a == acmux_pkg::OFF_RES_LO || a == acmux_pkg::OFF_RES_HI
        || a == acmux_pkg::OFF_IRQ_ST || a == acmux_pkg::OFF_IRQ_MSK;
  endfunction

  function automatic logic wsel(input logic [7:0] a, input logic [7:0] off, input logic go);
    return go && (a == off);
  endfunction

  // ---- axi4-lite write path
  assign awready = !aw_got_q;
  assign wready = !w_got_q;
  assign do_wr = aw_got_q && w_got_q && !bvalid_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (awvalid && !aw_got_q) begin
      aw_got_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (do_wr) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
    end else if (wvalid && !w_got_q) begin
      w_got_q <= 1'b1;
      w_data_q <= wdata[7:0];
      w_lane_q <= wstrb[0];
    end else if (do_wr) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= acmux_pkg::RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= is_mapped(aw_addr_q) ? acmux_pkg::RESP_OKAY : acmux_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  // ---- axi4-lite read path
  assign arready = !rvalid_q;
  assign ar_hs = arvalid && !rvalid_q;

  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      acmux_pkg::OFF_CSRA: rd_val = {en_q, state_q == acmux_pkg::CONV_BUSY,
                                     ate_q, flag_q, ie_q, ps_q};
      acmux_pkg::OFF_CSRB: rd_val = {1'b0, muxen_q, 3'h0, ts_q};
      acmux_pkg::OFF_MUXSEL: rd_val = {2'h0, ladj_q, 1'b0, ch_q};
      acmux_pkg::OFF_CMP_DIS: rd_val = {6'h00, dis_q};
      acmux_pkg::OFF_RES_LO: rd_val = ladj_q ? {res_q[1:0], 6'h00} : res_q[7:0];
      acmux_pkg::OFF_RES_HI: rd_val = ladj_q ? res_q[9:2] : {6'h00, res_q[9:8]};
      acmux_pkg::OFF_IRQ_ST: rd_val = {6'h00, drop_q, flag_q};
      acmux_pkg::OFF_IRQ_MSK: rd_val = {6'h00, drop_mask_q, ie_q};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= acmux_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_val};
      rresp_q <= rd_hit ? acmux_pkg::RESP_OKAY : acmux_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ---- control registers
  assign wr_csra = wsel(aw_addr_q, acmux_pkg::OFF_CSRA, do_wr && w_lane_q);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= acmux_pkg::RST_CSRA[acmux_pkg::CSRA_EN];
      ate_q <= acmux_pkg::RST_CSRA[acmux_pkg::CSRA_ATE];
      ie_q <= acmux_pkg::RST_CSRA[acmux_pkg::CSRA_IE];
      ps_q <= acmux_pkg::RST_CSRA[2:0];
    end else if (wr_csra) begin
      en_q <= w_data_q[acmux_pkg::CSRA_EN];
      ate_q <= w_data_q[acmux_pkg::CSRA_ATE];
      ie_q <= w_data_q[acmux_pkg::CSRA_IE];
      ps_q <= w_data_q[2:0];
    end else if (wsel(aw_addr_q, acmux_pkg::OFF_IRQ_MSK, do_wr && w_lane_q)) begin
      ie_q <= w_data_q[acmux_pkg::IRQ_DONE];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_mask_q <= 1'b0;
    end else if (wsel(aw_addr_q, acmux_pkg::OFF_IRQ_MSK, do_wr && w_lane_q)) begin
      drop_mask_q <= w_data_q[acmux_pkg::IRQ_DROP];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      muxen_q <= acmux_pkg::RST_CSRB[acmux_pkg::CSRB_MUXEN];
      ts_q <= acmux_pkg::RST_CSRB[2:0];
    end else if (wsel(aw_addr_q, acmux_pkg::OFF_CSRB, do_wr && w_lane_q)) begin
      muxen_q <= w_data_q[acmux_pkg::CSRB_MUXEN];
      ts_q <= w_data_q[2:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ladj_q <= acmux_pkg::RST_MUXSEL[acmux_pkg::MUXSEL_LADJ];
      ch_q <= acmux_pkg::RST_MUXSEL[3:0];
    end else if (wsel(aw_addr_q, acmux_pkg::OFF_MUXSEL, do_wr && w_lane_q)) begin
      ladj_q <= w_data_q[acmux_pkg::MUXSEL_LADJ];
      ch_q <= w_data_q[3:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dis_q <= acmux_pkg::RST_CMP_DIS;
    end else if (wsel(aw_addr_q, acmux_pkg::OFF_CMP_DIS, do_wr && w_lane_q)) begin
      dis_q <= w_data_q[1:0];
    end
  end

  // ---- converter clock
  acmux_prescaler #(
    .CNT_W(7)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(en_q),
    .sel(ps_q),
    .tick(tick)
  );

  // ---- conversion engine
  assign en_next = wr_csra ? w_data_q[acmux_pkg::CSRA_EN] : en_q;
  assign en_rise = wr_csra && w_data_q[acmux_pkg::CSRA_EN] && !en_q;
  assign kill = wr_csra && !w_data_q[acmux_pkg::CSRA_EN];
  assign trig_rise = trigger[ts_q] && !trig_prev_q;
  // writing zero to the start bit is simply not a start
  assign start_go = state_q == acmux_pkg::CONV_IDLE && en_next
      && ((wr_csra && w_data_q[acmux_pkg::CSRA_SC])
          || (ate_q && trig_rise));
  assign conv_done = state_q == acmux_pkg::CONV_BUSY && tick && !kill
      && tcnt_q == target_q - 5'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trigger[ts_q];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      first_q <= 1'b0;
    end else if (start_go) begin
      first_q <= 1'b0;
    end else if (en_rise) begin
      first_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= acmux_pkg::CONV_IDLE;
      tcnt_q <= 5'h00;
      target_q <= acmux_pkg::NORMAL_CONV_CLKS;
    end else if (kill) begin
      state_q <= acmux_pkg::CONV_IDLE;
      tcnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        acmux_pkg::CONV_IDLE: begin
          if (start_go) begin
            state_q <= acmux_pkg::CONV_BUSY;
            tcnt_q <= 5'h00;
            target_q <= (first_q || en_rise) ? acmux_pkg::FIRST_CONV_CLKS
                                             : acmux_pkg::NORMAL_CONV_CLKS;
          end
        end
        acmux_pkg::CONV_BUSY: begin
          if (conv_done) begin
            state_q <= acmux_pkg::CONV_IDLE;
          end else if (tick) begin
            tcnt_q <= tcnt_q + 5'h01;
          end
        end
      endcase
    end
  end

  // ---- result and read lock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      res_q <= acmux_pkg::RST_RESULT;
    end else if (conv_done && !lock_q) begin
      res_q <= conv_result;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q <= 1'b0;
    end else if (ar_hs && araddr == acmux_pkg::OFF_RES_LO) begin
      lock_q <= 1'b1;
    end else if (ar_hs && araddr == acmux_pkg::OFF_RES_HI) begin
      lock_q <= 1'b0;
    end
  end

  // ---- sticky flags, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= (conv_done && !lock_q)
          || (flag_q && !(irq_vector_ack
              || (wr_csra && w_data_q[acmux_pkg::CSRA_IF])
              || (wsel(aw_addr_q, acmux_pkg::OFF_IRQ_ST, do_wr && w_lane_q)
                  && w_data_q[acmux_pkg::IRQ_DONE])));
    end
  end

  // conversion finished while the result was locked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= (conv_done && lock_q)
          || (drop_q && !(wsel(aw_addr_q, acmux_pkg::OFF_IRQ_ST, do_wr && w_lane_q)
              && w_data_q[acmux_pkg::IRQ_DROP]));
    end
  end

  assign irq = global_irq_enable
      && ((flag_q && ie_q) || (drop_q && drop_mask_q));

  // ---- analogue selection
  always_comb begin
    conv_ctl.enable = en_q;
    conv_ctl.active = state_q == acmux_pkg::CONV_BUSY;
    conv_ctl.pin_valid = !ch_q[3];
    conv_ctl.pin_channel = ch_q[2:0];
    conv_ctl.bandgap = ch_q == acmux_pkg::CH_BANDGAP;
    conv_ctl.ground = ch_q == acmux_pkg::CH_GROUND;
    cmp_neg.from_mux = muxen_q && !en_q;
    cmp_neg.channel = (muxen_q && !en_q) ? ch_q[2:0] : 3'h0;
  end

  // ---- comparator pin inputs
  for (genvar i = 0; i < 2; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        pin_s1_q[i] <= 1'b0;
        pin_s2_q[i] <= 1'b0;
        pin_s3_q[i] <= 1'b0;
        pin_q[i] <= 1'b0;
      end else begin
        pin_s1_q[i] <= cmp_pin[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_q[i] <= pin_s3_q[i];
        end
      end
    end
    assign cmp_pin_buf_en[i] = !dis_q[i];
    assign cmp_pin_read[i] = pin_q[i] && !dis_q[i];
  end

endmodule

// file: bench/acmux_assertions.sv
`timescale 1ns/10ps
module acmux_assertions (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // interrupt and converter side
  input wire logic global_irq_enable,
  input wire logic irq,
  input wire acmux_pkg::acmux_conv_ctl_t conv_ctl,
  input wire acmux_pkg::acmux_cmp_neg_t cmp_neg,
  input wire logic [1:0] cmp_pin_buf_en,
  input wire logic [1:0] cmp_pin_read
);
  default clocking dcb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_neg_mux_off: assert property (cmp_neg.from_mux |-> !conv_ctl.enable)
    else $error("comparator mux used while converter on");
  a_neg_pin_chan: assert property (!cmp_neg.from_mux |-> cmp_neg.channel == 3'h0)
    else $error("channel shown while dedicated pin selected");
  a_pin_read_zero: assert property ((cmp_pin_buf_en == 2'h0) [*2] |-> cmp_pin_read == 2'h0)
    else $error("disabled pin reads nonzero");
  a_irq_gated: assert property (irq |-> global_irq_enable)
    else $error("interrupt without global enable");
  a_busy_needs_en: assert property (conv_ctl.active |-> conv_ctl.enable)
    else $error("busy while converter off");
  a_chan_onehot: assert property ($onehot0({conv_ctl.pin_valid, conv_ctl.bandgap,
    conv_ctl.ground}))
    else $error("channel decode overlaps");
  a_conv_min_len: assert property ($rose(conv_ctl.active) ##1 conv_ctl.enable [*8]
    |-> conv_ctl.active)
    else $error("conversion ended too soon");
  a_wresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
endmodule

bind acmux_top acmux_assertions u_chk (.aclk, .aresetn, .arvalid, .arready, .rvalid, .rready,
  .rdata, .bvalid, .bready, .bresp, .global_irq_enable, .irq, .conv_ctl, .cmp_neg,
  .cmp_pin_buf_en, .cmp_pin_read);

// file: bench/acmux_top_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module acmux_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp, cmp_pin_buf_en, cmp_pin_read, r;
  logic [1:0] cmp_pin = 2'h3;
  logic global_irq_enable = 1'b0, irq_vector_ack = 1'b0;
  logic [7:0] trigger = 8'h00;
  logic [9:0] conv_result = 10'h2c5;
  acmux_pkg::acmux_conv_ctl_t conv_ctl;
  acmux_pkg::acmux_cmp_neg_t cmp_neg;
  int miscompares = 0, check_count = 0;

  always #25 aclk = ~aclk;

  acmux_top dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .global_irq_enable, .irq_vector_ack, .irq, .trigger,
    .conv_result, .conv_ctl, .cmp_neg, .cmp_pin, .cmp_pin_buf_en, .cmp_pin_read);

  task complete_run;
    if (miscompares == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // whole-byte writes only, never read-modify-write
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    bready <= 1'b0;
    r = bresp;
    if (n >= 200) miscompares++;
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n >= 200) miscompares++;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (conv_ctl.active === 1'b1 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    if (n >= 20000) miscompares++;
  endtask

  task t_reset;
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, 32'h0)
    rd(acmux_pkg::OFF_CMP_DIS);
    `CHK(d, 32'h0)
    rd(8'h20);
    `CHK(r, acmux_pkg::RESP_SLVERR)
    wr(8'h20, 8'h00);
    `CHK(r, acmux_pkg::RESP_SLVERR)
  endtask

  task t_mux;
    wr(acmux_pkg::OFF_CSRB, 8'h40);
    for (int c = 0; c < 8; c++) begin
      wr(acmux_pkg::OFF_MUXSEL, c[7:0]);
      `CHK(cmp_neg, {1'b1, c[2:0]})
    end
    wr(acmux_pkg::OFF_CSRA, 8'h80);
    `CHK(cmp_neg.from_mux, 1'b0)
    wr(acmux_pkg::OFF_CSRA, 8'h00);
    wr(acmux_pkg::OFF_CSRB, 8'h00);
    `CHK(cmp_neg.from_mux, 1'b0)
  endtask

  task t_decode;
    wr(acmux_pkg::OFF_CSRA, 8'h80);
    for (int c = 0; c < 16; c++) begin
      wr(acmux_pkg::OFF_MUXSEL, c[7:0]);
      `CHK(conv_ctl.pin_valid, c < 8)
      `CHK(conv_ctl.bandgap, c == 14)
      `CHK(conv_ctl.ground, c == 15)
      if (c < 8) `CHK(conv_ctl.pin_channel, c[2:0])
    end
    wr(acmux_pkg::OFF_MUXSEL, 8'h00);
    wr(acmux_pkg::OFF_CSRA, 8'h00);
  endtask

  task t_pins;
    wr(acmux_pkg::OFF_CMP_DIS, 8'hff);
    rd(acmux_pkg::OFF_CMP_DIS);
    `CHK(d, 32'h3)
    repeat (6) @(posedge aclk);
    `CHK(cmp_pin_buf_en, 2'h0)
    `CHK(cmp_pin_read, 2'h0)
    wr(acmux_pkg::OFF_CMP_DIS, 8'h01);
    repeat (6) @(posedge aclk);
    `CHK(cmp_pin_buf_en, 2'h2)
    `CHK(cmp_pin_read, 2'h2)
    cmp_pin <= 2'h1;
    repeat (6) @(posedge aclk);
    `CHK(cmp_pin_read, 2'h0)
    cmp_pin <= 2'h3;
    wr(acmux_pkg::OFF_CMP_DIS, 8'h00);
    repeat (6) @(posedge aclk);
    `CHK(cmp_pin_read, 2'h3)
  endtask

  // one started conversion, length checked against the prescaler
  task automatic conv(input logic [2:0] ps, input int ticks);
    int n, dv;
    dv = (ps < 2) ? 2 : (1 << ps);
    n = 0;
    wr(acmux_pkg::OFF_CSRA, {5'b11000, ps});
    while (conv_ctl.active === 1'b1 && n < 20000) begin
      @(posedge aclk);
      n++;
    end
    `CHK(n >= dv * (ticks - 1) && n <= dv * ticks + 1, 1'b1)
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, {24'h0, 5'b10010, ps})
    wr(acmux_pkg::OFF_CSRA, {5'b10010, ps});
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, {24'h0, 5'b10000, ps})
  endtask

  task t_conv;
    conv(3'h0, 25);
    for (int p = 0; p < 8; p++) conv(p[2:0], 13);
    rd(acmux_pkg::OFF_RES_LO);
    `CHK(d, 32'hc5)
    rd(acmux_pkg::OFF_RES_HI);
    `CHK(d, 32'h2)
    wr(acmux_pkg::OFF_MUXSEL, 8'h20);
    rd(acmux_pkg::OFF_RES_LO);
    `CHK(d, 32'h40)
    rd(acmux_pkg::OFF_RES_HI);
    `CHK(d, 32'hb1)
    wr(acmux_pkg::OFF_MUXSEL, 8'h00);
  endtask

  task t_lock;
    conv_result <= 10'h1a3;
    rd(acmux_pkg::OFF_RES_LO);
    wr(acmux_pkg::OFF_CSRA, 8'hc0);
    wait_idle;
    rd(acmux_pkg::OFF_RES_HI);
    `CHK(d, 32'h2)
    rd(acmux_pkg::OFF_IRQ_ST);
    `CHK(d, 32'h2)
    wr(acmux_pkg::OFF_IRQ_ST, 8'h02);
  endtask

  task t_irq;
    wr(acmux_pkg::OFF_CSRA, 8'hc0);
    wait_idle;
    `CHK(irq, 1'b0)
    wr(acmux_pkg::OFF_CSRA, 8'h88);
    `CHK(irq, 1'b0)
    @(posedge aclk) global_irq_enable <= 1'b1;
    @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(acmux_pkg::OFF_IRQ_MSK, 8'h00);
    `CHK(irq, 1'b0)
    wr(acmux_pkg::OFF_IRQ_MSK, 8'h01);
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, 32'h98)
    @(posedge aclk) irq_vector_ack <= 1'b1;
    @(posedge aclk) irq_vector_ack <= 1'b0;
    @(posedge aclk);
    `CHK(irq, 1'b0)
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, 32'h88)
  endtask

  task t_abort;
    wr(acmux_pkg::OFF_CSRA, 8'hc0);
    `CHK(conv_ctl.active, 1'b1)
    wr(acmux_pkg::OFF_CSRA, 8'h00);
    `CHK(conv_ctl.active, 1'b0)
    repeat (60) @(posedge aclk);
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, 32'h0)
  endtask

  task t_trig;
    wr(acmux_pkg::OFF_CSRB, 8'h03);
    wr(acmux_pkg::OFF_CSRA, 8'ha0);
    @(posedge aclk) trigger <= 8'h04;
    @(posedge aclk) trigger <= 8'h00;
    repeat (3) @(posedge aclk);
    `CHK(conv_ctl.active, 1'b0)
    trigger <= 8'h08;
    repeat (3) @(posedge aclk);
    `CHK(conv_ctl.active, 1'b1)
    trigger <= 8'h00;
    wait_idle;
    rd(acmux_pkg::OFF_CSRA);
    `CHK(d, 32'hb0)
    wr(acmux_pkg::OFF_CSRA, 8'h10);
    wr(acmux_pkg::OFF_CSRB, 8'h00);
  endtask

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_mux;
    t_decode;
    t_pins;
    t_conv;
    t_lock;
    t_irq;
    // mid-run reset while control a and the mask hold nonzero values
    @(posedge aclk) aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    `CHK(irq, 1'b0)
    t_abort;
    t_trig;
    complete_run;
  end

  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    complete_run;
  end
endmodule
